// *** bio_pkg.sv ***
package bio_pkg;

  // ************************************************************
  // register map, byte addresses in data space
  // ************************************************************
  localparam logic [7:0] port_a_data_addr      = 8'hc0;
  localparam logic [7:0] port_b_data_addr      = 8'hc1;
  localparam logic [7:0] port_c_data_addr      = 8'hc3;
  localparam logic [7:0] port_a_direction_addr = 8'hc4;
  localparam logic [7:0] port_b_direction_addr = 8'hc5;
  localparam logic [7:0] port_c_direction_addr = 8'hc6;
  localparam logic [7:0] port_a_option_addr    = 8'hcc;
  localparam logic [7:0] port_b_option_addr    = 8'hcd;
  localparam logic [7:0] port_c_option_addr    = 8'hcf;

  // ************************************************************
  // reset values and implemented lines
  // ************************************************************
  localparam logic [7:0] port_reset_value   = 8'h00;
  localparam logic [7:0] port_c_option_rst  = 8'hff;
  localparam logic [7:0] port_c_data_rst    = 8'hff;
  localparam logic [7:0] port_a_impl_mask   = 8'he0;
  localparam logic [7:0] port_b_impl_mask   = 8'hff;
  localparam logic [7:0] port_c_impl_mask   = 8'hff;
  localparam logic [7:0] unimpl_read_value  = 8'h00;
  localparam logic [7:0] analog_a_mask      = 8'he0;
  localparam logic [7:0] analog_b_mask      = 8'h0f;

  // ************************************************************
  // field positions and per-line modes
  // ************************************************************
  localparam int spi_clk_bit  = 5;
  localparam int spi_din_bit  = 6;
  localparam int spi_dout_bit = 7;

  typedef enum logic [2:0] {
    mode_in_pullup,
    mode_in_float,
    mode_in_irq,
    mode_in_special,
    mode_out_open_drain,
    mode_out_push_pull
  } bio_mode_type;

endpackage

// *** bio_line.sv ***
`timescale 1ns/10ps
// one I/O line: mode decode, pad drive and pin synchroniser
module bio_line
  import bio_pkg::*;
#(
  parameter bit analog_able = 1'b0,
  parameter bit lcd_able    = 1'b0,
  parameter bit spi_out     = 1'b0
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // configuration
  input  wire logic direction_bit,
  input  wire logic option_bit,
  input  wire logic line_data_bit,
  // alternate sources
  input  wire logic lcd_segment_in,
  input  wire logic spi_tx_in,
  // pad
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      pullup_en,
  output logic      pin_level,
  output logic      irq_line,
  output logic      analog_sel,
  output logic      lcd_sel
);

  logic         sync1_q;
  logic         sync2_q;
  bio_mode_type mode;

  // decode of direction, option and data bits
  always_comb begin
    case ({direction_bit, option_bit, line_data_bit})
      3'h0:    mode = mode_in_pullup;
      3'h1:    mode = mode_in_float;
      3'h2:    mode = mode_in_irq;
      3'h3:    mode = mode_in_special;
      3'h4,
      3'h5:    mode = mode_out_open_drain;
      3'h6,
      3'h7:    mode = mode_out_push_pull;
      default: mode = mode_in_pullup;
    endcase
  end

  // pin passes two flops; the first is read only by the second
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // registered pad controls, so outputs come from flops
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_out    <= 1'b0;
      pin_oe     <= 1'b0;
      pullup_en  <= 1'b1;
      pin_level  <= 1'b1;
      irq_line   <= 1'b0;
      analog_sel <= 1'b0;
      lcd_sel    <= 1'b0;
    end else begin
      pin_level  <= sync2_q;
      pullup_en  <= (mode == mode_in_pullup) || (mode == mode_in_irq);
      irq_line   <= (mode == mode_in_irq) && sync2_q;
      analog_sel <= analog_able && (mode == mode_in_special);
      lcd_sel    <= lcd_able && (mode == mode_in_special);
      case (mode)
        // open drain only pulls low; serial data leaves here on the spi line
        mode_out_open_drain: begin
          pin_out <= 1'b0;
          pin_oe  <= spi_out ? !(line_data_bit && spi_tx_in) : !line_data_bit;
        end
        // push-pull carries only the latch, never the serial data
        mode_out_push_pull: begin
          pin_out <= line_data_bit;
          pin_oe  <= 1'b1;
        end
        mode_in_special: begin
          pin_out <= lcd_able ? lcd_segment_in : 1'b0;
          pin_oe  <= lcd_able;
        end
        default: begin
          pin_out <= 1'b0;
          pin_oe  <= 1'b0;
        end
      endcase
    end
  end

endmodule

// *** bio_port.sv ***
// Operation
// - input decode: 00 pull-up, 01 floating, 10 pull-up with interrupt, 11 analog
// - output: option 0 open-drain, option 1 push-pull; data is level only
// - analog mode routes line to converter mux; only PA5-PA7 and PB0-PB3
// - input-mode reads return pin level; writes still update the latch
// - digital input on all lines; reset gives pull-up input except port C
// - port C combination 011 selects LCD segment; also its reset state
// - port C lines in LCD mode carry segments 33 to 40 in order
// - serial clock and data-in work in any input mode, pins still readable
// - serial out line carries transmit data only as open-drain output
// - option and direction registers 8 bits, bit n for line n, read-write; port A bits 0-4 fixed at zero
// - initialization clears port A and B registers: pull-up inputs without interrupt
// - interrupt-mode inputs feed interrupt system with software trigger mode
`timescale 1ns/10ps
module bio_port
  import bio_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // data-space access
  input  wire logic [7:0]  ds_addr,
  input  wire logic        ds_wr,
  input  wire logic        ds_rd,
  input  wire logic [7:0]  ds_wdata,
  output logic      [7:0]  ds_rdata,
  output logic             ds_hit,
  // pads, ports a b c as one 24-bit vector
  input  wire logic [23:0] pin_in,
  output logic      [23:0] pin_out,
  output logic      [23:0] pin_oe,
  output logic      [23:0] pullup_en,
  // interrupt system, one level per line
  output logic      [23:0] irq_line,
  // converter multiplexer selects, PA5-PA7 then PB0-PB3
  output logic      [6:0]  analog_sel,
  // lcd controller
  input  wire logic [7:0]  lcd_segment_outputs,
  output logic      [7:0]  lcd_sel,
  // serial peripheral
  input  wire logic        spi_tx,
  output logic             spi_clk_in,
  output logic             spi_data_in
);

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [7:0]  dir_a_q;
  logic [7:0]  dir_b_q;
  logic [7:0]  dir_c_q;
  logic [7:0]  opt_a_q;
  logic [7:0]  opt_b_q;
  logic [7:0]  opt_c_q;
  logic [7:0]  dat_a_q;
  logic [7:0]  dat_b_q;
  logic [7:0]  port_c_data_latch_q;
  logic [23:0] level;
  logic [23:0] asel;
  logic [23:0] lsel;
  logic [23:0] dir_all;
  logic [23:0] opt_all;
  logic [23:0] dat_all;
  logic [7:0]  wmask;
  logic [7:0]  rd_d;
  logic        hit_d;
  // one write strobe per register, decoded once
  logic        we_dir_a;
  logic        we_dir_b;
  logic        we_dir_c;
  logic        we_opt_a;
  logic        we_opt_b;
  logic        we_opt_c;
  logic        we_dat_a;
  logic        we_dat_b;
  logic        we_dat_c;
  // write data after the per-port mask
  logic [7:0]  wr_val;
  // data register read values, one per port
  logic [7:0]  rd_dat_a;
  logic [7:0]  rd_dat_b;
  logic [7:0]  rd_dat_c;

  // flat views of the registers, line g at bit g
  assign dir_all = {dir_c_q, dir_b_q, dir_a_q};
  assign opt_all = {opt_c_q, opt_b_q, opt_a_q};
  assign dat_all = {port_c_data_latch_q, dat_b_q, dat_a_q};

  // ************************************************************
  // write masks
  // ************************************************************
  // write mask per port so unimplemented bits stay fixed
  always_comb begin
    case (ds_addr)
      port_a_data_addr, port_a_direction_addr, port_a_option_addr: wmask = port_a_impl_mask;
      port_b_data_addr, port_b_direction_addr, port_b_option_addr: wmask = port_b_impl_mask;
      default:                                                     wmask = port_c_impl_mask;
    endcase
  end

  // absent port a bits keep their reset zero, so those lines idle as pulled-up inputs
  assign wr_val = ds_wdata & wmask;

  // ************************************************************
  // write decode
  // ************************************************************
  // a strobe needs ds_wr and an exact address match; unmapped writes change nothing
  // a data write lands even for input lines, since it picks the input flavour
  assign we_dir_a = ds_wr && (ds_addr == port_a_direction_addr);
  assign we_dir_b = ds_wr && (ds_addr == port_b_direction_addr);
  assign we_dir_c = ds_wr && (ds_addr == port_c_direction_addr);
  assign we_opt_a = ds_wr && (ds_addr == port_a_option_addr);
  assign we_opt_b = ds_wr && (ds_addr == port_b_option_addr);
  assign we_opt_c = ds_wr && (ds_addr == port_c_option_addr);
  assign we_dat_a = ds_wr && (ds_addr == port_a_data_addr);
  assign we_dat_b = ds_wr && (ds_addr == port_b_data_addr);
  assign we_dat_c = ds_wr && (ds_addr == port_c_data_addr);

  // ************************************************************
  // register storage, one process per register
  // ************************************************************
  // port a direction
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dir_a_q <= port_reset_value;
    end else if (we_dir_a) begin
      dir_a_q <= wr_val;
    end
  end

  // port b direction
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dir_b_q <= port_reset_value;
    end else if (we_dir_b) begin
      dir_b_q <= wr_val;
    end
  end

  // port c direction
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dir_c_q <= port_reset_value;
    end else if (we_dir_c) begin
      dir_c_q <= wr_val;
    end
  end

  // port a option
  always_ff @(posedge core_clk) begin
    if (reset) begin
      opt_a_q <= port_reset_value;
    end else if (we_opt_a) begin
      opt_a_q <= wr_val;
    end
  end

  // port b option
  always_ff @(posedge core_clk) begin
    if (reset) begin
      opt_b_q <= port_reset_value;
    end else if (we_opt_b) begin
      opt_b_q <= wr_val;
    end
  end

  // port c option; port c comes up in lcd mode
  always_ff @(posedge core_clk) begin
    if (reset) begin
      opt_c_q <= port_c_option_rst;
    end else if (we_opt_c) begin
      opt_c_q <= wr_val;
    end
  end

  // port a data latch
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dat_a_q <= port_reset_value;
    end else if (we_dat_a) begin
      dat_a_q <= wr_val;
    end
  end

  // port b data latch
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dat_b_q <= port_reset_value;
    end else if (we_dat_b) begin
      dat_b_q <= wr_val;
    end
  end

  // port c data latch; ones here together with the options give lcd mode
  always_ff @(posedge core_clk) begin
    if (reset) begin
      port_c_data_latch_q <= port_c_data_rst;
    end else if (we_dat_c) begin
      port_c_data_latch_q <= wr_val;
    end
  end

  // ************************************************************
  // per-line logic
  // ************************************************************
  // every line has its own instance, the five absent port a lines too;
  // their registers stay masked to zero, so they idle as pulled-up inputs
  genvar g;
  generate
    for (g = 0; g < 24; g++) begin : g_line
      bio_line #(
        .analog_able ((g >= 5 && g <= 11) ? 1'b1 : 1'b0),
        .lcd_able    ((g >= 16) ? 1'b1 : 1'b0),
        .spi_out     ((g == 8 + spi_dout_bit) ? 1'b1 : 1'b0)
      ) u_line (
        .core_clk       (core_clk),
        .reset          (reset),
        .direction_bit  (dir_all[g]),
        .option_bit     (opt_all[g]),
        .line_data_bit  (dat_all[g]),
        .lcd_segment_in ((g >= 16) ? lcd_segment_outputs[g % 8] : 1'b0),
        .spi_tx_in      (spi_tx),
        .pin_in         (pin_in[g]),
        .pin_out        (pin_out[g]),
        .pin_oe         (pin_oe[g]),
        .pullup_en      (pullup_en[g]),
        .pin_level      (level[g]),
        .irq_line       (irq_line[g]),
        .analog_sel     (asel[g]),
        .lcd_sel        (lsel[g])
      );
    end
  endgenerate

  // ************************************************************
  // alternate-function outputs
  // ************************************************************
  // selects are already flops inside each line
  assign analog_sel = asel[11:5];
  assign lcd_sel    = lsel[23:16];

  // serial inputs taken from the synchronised level in any input mode
  always_ff @(posedge core_clk) begin
    if (reset) begin
      spi_clk_in  <= 1'b0;
      spi_data_in <= 1'b0;
    end else begin
      spi_clk_in  <= level[8 + spi_clk_bit];
      spi_data_in <= level[8 + spi_din_bit];
    end
  end

  // ************************************************************
  // read path, one cycle after ds_rd
  // ************************************************************
  // output bits read back the latch, input bits the synchronised pin;
  // analog and lcd lines count as inputs here, so their reads show the pin
  assign rd_dat_a = (dat_a_q & dir_a_q) | (level[7:0] & ~dir_a_q);
  assign rd_dat_b = (dat_b_q & dir_b_q) | (level[15:8] & ~dir_b_q);
  assign rd_dat_c = (port_c_data_latch_q & dir_c_q) | (level[23:16] & ~dir_c_q);

  // register select for the read answer
  always_comb begin
    hit_d = 1'b1;
    case (ds_addr)
      port_a_data_addr:      rd_d = rd_dat_a;
      port_b_data_addr:      rd_d = rd_dat_b;
      port_c_data_addr:      rd_d = rd_dat_c;
      port_a_direction_addr: rd_d = dir_a_q;
      port_b_direction_addr: rd_d = dir_b_q;
      port_c_direction_addr: rd_d = dir_c_q;
      port_a_option_addr:    rd_d = opt_a_q;
      port_b_option_addr:    rd_d = opt_b_q;
      port_c_option_addr:    rd_d = opt_c_q;
      default: begin
        rd_d  = 8'h00;
        hit_d = 1'b0;
      end
    endcase
    if (ds_addr == port_a_data_addr) begin
      rd_d = (rd_d & port_a_impl_mask) | (unimpl_read_value & ~port_a_impl_mask);
    end
  end

  // ************************************************************
  // read answer
  // ************************************************************
  // read answer register; zero outside a read so a stale byte never lingers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ds_rdata <= 8'h00;
      ds_hit   <= 1'b0;
    end else begin
      ds_rdata <= ds_rd ? rd_d : 8'h00;
      ds_hit   <= ds_rd && hit_d;
    end
  end

endmodule

// *** bio_pad_model.sv ***
`timescale 1ns/10ps
// outside world at the pads: device drive wins, then an outside source, then the pull-up
module bio_pad_model (
  // clock
  input  wire logic        core_clk,
  // device drive and outside source
  input  wire logic [23:0] pin_out,
  input  wire logic [23:0] pin_oe,
  input  wire logic [23:0] pullup_en,
  input  wire logic [23:0] ext_en,
  input  wire logic [23:0] ext_val,
  output logic      [23:0] pin_in
);
  logic float_q = 1'b0;
  // a floating line wanders every cycle so it never reads as a settled value
  always @(posedge core_clk) float_q <= ~float_q;
  // device drive wins over an outside source, which wins over the pull-up
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & (pullup_en | {24{float_q}}));
endmodule

// *** bio_port_asserts.sv ***
`timescale 1ns/10ps
module bio_port_asserts
  import bio_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        reset,
  // register access
  input wire logic [7:0]  ds_addr,
  input wire logic        ds_wr,
  input wire logic        ds_rd,
  input wire logic [7:0]  ds_wdata,
  input wire logic [7:0]  ds_rdata,
  input wire logic        ds_hit,
  // pads and side outputs
  input wire logic [23:0] pin_in,
  input wire logic [23:0] pin_oe,
  input wire logic [23:0] pullup_en,
  input wire logic [23:0] irq_line,
  input wire logic [6:0]  analog_sel,
  input wire logic [7:0]  lcd_sel,
  input wire logic        spi_clk_in
);
  // ********************
  // line mode, register access and serial input relations
  // ********************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  AST_RESET_PULLUP: assert property (
    $fell(reset) |=> &pullup_en[15:5] && pin_oe[15:0] == 16'h0000)
    else $error("ports a and b not pulled-up inputs after reset");
  AST_NO_PULL_ON_DRIVE: assert property (
    (pin_oe & pullup_en) == 24'h000000)
    else $error("pull-up on while line is driven");
  AST_ANALOG_FLOATS: assert property (
    (({pin_oe[11:8], pin_oe[7:5]} | {pullup_en[11:8], pullup_en[7:5]}) & analog_sel) == 7'h00)
    else $error("analog line driven or pulled up");
  AST_IRQ_INPUT: assert property (
    (irq_line & (pin_oe | ~pullup_en)) == 24'h000000)
    else $error("interrupt on a line not a pulled-up input");
  AST_LCD_DRIVES: assert property (
    (lcd_sel & ~pin_oe[23:16]) == 8'h00)
    else $error("segment line not driven");
  AST_MISS_READS_ZERO: assert property (
    !ds_hit |-> ds_rdata == 8'h00)
    else $error("read data without a hit");
  AST_HIT_AFTER_READ: assert property (
    ds_rd && ds_addr == port_c_option_addr |=> ds_hit)
    else $error("mapped read gave no hit");
  AST_DIR_READBACK: assert property (
    ds_wr && ds_addr == port_b_direction_addr ##1 ds_rd && !ds_wr && ds_addr == port_b_direction_addr
    |=> ds_rdata == $past(ds_wdata, 2)) else $error("direction readback differs from write");
  AST_SPI_CLK_SYNC: assert property (
    $stable(pin_in[13])[*5] |-> spi_clk_in == pin_in[13])
    else $error("serial clock input does not follow its pin");
  C_ANALOG: cover property (analog_sel != 7'h00);
  C_IRQ: cover property (irq_line != 24'h000000);
  C_LCD_OFF: cover property (lcd_sel != 8'hff);
endmodule
bind bio_port bio_port_asserts u_asserts (.core_clk, .reset, .ds_addr, .ds_wr, .ds_rd, .ds_wdata, .ds_rdata,
  .ds_hit, .pin_in, .pin_oe, .pullup_en, .irq_line, .analog_sel, .lcd_sel, .spi_clk_in);

// *** tb.sv ***
`timescale 1ns/10ps
`define CHK(nm, ex, ac) begin check_count++; if ((ac) !== (ex)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, ac); end end
module tb
  import bio_pkg::*;
;
  // ********************
  // stimulus and observed nets
  // ********************
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  ds_addr = 8'h00;
  logic        ds_wr = 1'b0;
  logic        ds_rd = 1'b0;
  logic [7:0]  ds_wdata = 8'h00;
  logic [7:0]  lcd_segment_outputs = 8'h00;
  logic        spi_tx = 1'b0;
  logic [23:0] ext_en = 24'h000000;
  logic [23:0] ext_val = 24'h000000;
  logic [7:0]  ds_rdata, rdv, lcd_sel;
  logic        ds_hit, hitv, spi_clk_in, spi_data_in;
  logic [23:0] pin_in, pin_out, pin_oe, pullup_en, irq_line;
  logic [6:0]  analog_sel;
  int          error_cnt = 0;
  int          check_count = 0;
  int          cycle_cnt = 0;
  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;
  // hang guard, well above the roughly 150 cycles the run needs
  always @(posedge core_clk) begin
    cycle_cnt++;
    if (cycle_cnt == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  bio_port u_dut (.core_clk, .reset, .ds_addr, .ds_wr, .ds_rd, .ds_wdata, .ds_rdata, .ds_hit, .pin_in,
    .pin_out, .pin_oe, .pullup_en, .irq_line, .analog_sel, .lcd_segment_outputs, .lcd_sel, .spi_tx,
    .spi_clk_in, .spi_data_in);
  bio_pad_model u_pads (.core_clk, .pin_out, .pin_oe, .pullup_en, .ext_en, .ext_val, .pin_in);
  // bus tasks are entered at a falling edge; strobes stay up across back-to-back accesses
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ds_wr = 1'b1;
    ds_rd = 1'b0;
    ds_addr = a;
    ds_wdata = d;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    ds_rd = 1'b1;
    ds_wr = 1'b0;
    ds_addr = a;
    @(negedge core_clk);
    rdv = ds_rdata;
    hitv = ds_hit;
  endtask
  task automatic idle(input int n);
    ds_wr = 1'b0;
    ds_rd = 1'b0;
    repeat (n) @(negedge core_clk);
  endtask
  task automatic t_reset();
    `CHK("lcd select", 8'hff, lcd_sel)
    `CHK("pull-ups a b", 11'h7ff, pullup_en[15:5])
    `CHK("analog idle", 7'h00, analog_sel)
    rd(port_b_direction_addr);
    `CHK("dir b", port_reset_value, rdv)
    `CHK("mapped hit", 1'b1, hitv)
    rd(port_a_data_addr);
    `CHK("pa pins", 8'he0, rdv)
    rd(port_c_option_addr);
    `CHK("opt c", port_c_option_rst, rdv)
    idle(1);
  endtask
  task automatic t_regs();
    logic [7:0] adr [6] = '{port_a_direction_addr, port_b_direction_addr, port_c_direction_addr,
                            port_a_option_addr, port_b_option_addr, port_c_option_addr};
    for (int i = 0; i < 6; i++) begin
      wr(adr[i], 8'ha5);
      rd(adr[i]);
      `CHK("readback", (i % 3 == 0) ? (8'ha5 & port_a_impl_mask) : 8'ha5, rdv)
    end
    rd(8'hc2);
    `CHK("unmapped data", unimpl_read_value, rdv)
    `CHK("unmapped hit", 1'b0, hitv)
    for (int i = 0; i < 6; i++) wr(adr[i], (i == 5) ? port_c_option_rst : port_reset_value);
    idle(3);
  endtask
  task automatic t_modes();
    logic [2:0] cfg [7] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b100, 3'b101, 3'b111};
    logic [3:0] exp [7] = '{4'b0100, 4'b0000, 4'b0110, 4'b0001, 4'b1000, 4'b0000, 4'b1000};
    for (int i = 0; i < 7; i++) begin
      wr(port_b_data_addr, {7'h00, cfg[i][0]});
      wr(port_b_option_addr, {7'h00, cfg[i][1]});
      wr(port_b_direction_addr, {7'h00, cfg[i][2]});
      idle(8);
      `CHK("pb0 oe pu irq an", exp[i], {pin_oe[8], pullup_en[8], irq_line[8], analog_sel[3]})
      `CHK("analog sel", exp[i][0] ? 7'h08 : 7'h00, analog_sel)
      if (exp[i][3]) begin
        `CHK("pb0 level", cfg[i][0], pin_out[8])
      end
    end
    wr(port_b_direction_addr, 8'h00);
  endtask
  task automatic t_read_pin();
    wr(port_b_direction_addr, 8'h0f);
    wr(port_b_option_addr, 8'h0f);
    wr(port_b_data_addr, 8'h3c);
    ext_en = 24'h00f000;
    ext_val = 24'h00a000;
    idle(6);
    rd(port_b_data_addr);
    `CHK("pb mixed read", 8'hac, rdv)
    `CHK("pb drive", 4'hc, pin_out[11:8])
    `CHK("serial clock in", 1'b1, spi_clk_in)
    `CHK("serial data in", 1'b0, spi_data_in)
    ext_en = 24'h000000;
    wr(port_b_direction_addr, 8'hff);
    idle(3);
    rd(port_b_data_addr);
    `CHK("pb latch read", 8'h3c, rdv)
    wr(port_b_option_addr, 8'h00);
  endtask
  task automatic t_spi_out();
    wr(port_b_data_addr, 8'h80);
    wr(port_b_direction_addr, 8'h80);
    idle(4);
    `CHK("sout open drain low", 2'b10, {pin_oe[15], pin_out[15]})
    spi_tx = 1'b1;
    idle(4);
    `CHK("sout released", 1'b0, pin_oe[15])
    wr(port_b_option_addr, 8'h80);
    spi_tx = 1'b0;
    idle(4);
    `CHK("sout push-pull", 2'b11, {pin_oe[15], pin_out[15]})
  endtask
  task automatic t_lcd();
    lcd_segment_outputs = 8'h1e;
    idle(4);
    `CHK("segments on pins", 8'h1e, pin_out[23:16])
    wr(port_c_direction_addr, 8'h01);
    idle(3);
    `CHK("pc0 leaves lcd", 8'hfe, lcd_sel)
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // reset for three cycles, then each scenario in turn
  initial begin
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    @(negedge core_clk);
    t_reset();
    t_regs();
    t_modes();
    t_read_pin();
    t_spi_out();
    t_lcd();
    report_and_stop();
  end
endmodule
